// *** rtl/lps_pkg.sv ***
// package: constants and carrier types for the display power and sleep control block
package lps_pkg;

  // ****************************************************************
  // command encodings
  // ****************************************************************
  localparam logic [3:0] LPS_OP_PWR_SAVE = 4'h4;
  localparam logic [3:0] LPS_OP_PWR_CTRL = 4'h5;
  localparam logic [3:0] LPS_OP_CONTRAST = 4'h7;
  localparam logic [3:0] LPS_OP_DISP_CTRL = 4'h3;
  localparam logic [3:0] LPS_OP_SYS_SET = 4'h6;
  localparam int LPS_BIT_PC_ZERO = 3;
  localparam int LPS_BIT_REG = 2;
  localparam int LPS_BIT_FOL = 1;
  localparam int LPS_BIT_BOOST = 0;
  localparam int LPS_BIT_OSC = 1;
  localparam int LPS_BIT_SLEEP = 0;
  localparam int LPS_BIT_CG = 0;
  localparam int LPS_BIT_CURSOR = 3;
  localparam int LPS_BIT_BLINK = 2;
  localparam int LPS_BIT_DBL = 1;
  localparam int LPS_BIT_DISP = 0;
  localparam int LPS_N_SUPPLY = 3;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int LPS_CONTRAST_W = 4;
  localparam logic [LPS_CONTRAST_W-1:0] LPS_CONTRAST_RST = 4'h0;
  localparam logic [2:0] LPS_BITCNT_RST = 3'h0;
  localparam logic [2:0] LPS_BITCNT_LAST = 3'h7;
  localparam logic [LPS_N_SUPPLY-1:0] LPS_SUPPLY_RST = 3'h0;
  localparam logic [LPS_BIT_CURSOR:LPS_BIT_DISP] LPS_DISP_RST = 4'h0;

  // settings held across sleep and presented to the analogue side
  typedef struct packed {
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic dbl_cursor_on;
    logic osc_en;
    logic sleep_req;
    logic regulator_en;
    logic follower_en;
    logic booster_en;
    logic cg_use;
    logic [LPS_CONTRAST_W-1:0] contrast;
  } lps_settings_t;

  localparam lps_settings_t LPS_SETTINGS_RST = '{
    disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0, dbl_cursor_on: 1'b0,
    osc_en: 1'b0, sleep_req: 1'b0, regulator_en: 1'b0, follower_en: 1'b0,
    booster_en: 1'b0, cg_use: 1'b0, contrast: LPS_CONTRAST_RST};

  // one received byte from the host interface
  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] byte_val;
  } lps_word_t;

endpackage : lps_pkg

// *** rtl/lps_host_if.sv ***
// module: chip-select gated parallel and serial host capture
`timescale 1ns/1ps
module lps_host_if (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic par_sel,
  input wire logic cs_n,
  input wire logic cmd_data_sel,
  input wire logic wr_strobe,
  input wire logic [7:0] data_bus,
  input wire logic ser_data,
  input wire logic ser_clk,
  output lps_pkg::lps_word_t word_out
);
  import lps_pkg::*;

  logic wr_d_reg;
  logic scl_d_reg;
  logic [7:0] shift_reg;
  logic [2:0] bitcnt_reg;
  logic wr_rise;
  logic scl_rise;

  // edges only count while selected, so a deselected bus is fully ignored
  assign wr_rise = !cs_n && par_sel && wr_strobe && !wr_d_reg;
  assign scl_rise = !cs_n && !par_sel && ser_clk && !scl_d_reg;

  // ****************************************************************
  // edge history
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_d_reg <= 1'b0;
      scl_d_reg <= 1'b0;
    end else begin
      wr_d_reg <= wr_strobe;
      scl_d_reg <= ser_clk;
    end
  end

  // ****************************************************************
  // serial shift register and bit counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
      bitcnt_reg <= LPS_BITCNT_RST;
    end else if (cs_n) begin
      shift_reg <= 8'h00;
      bitcnt_reg <= LPS_BITCNT_RST;
    end else if (scl_rise) begin
      shift_reg <= {shift_reg[6:0], ser_data};
      bitcnt_reg <= bitcnt_reg + 3'h1;
    end
  end

  // ****************************************************************
  // word output
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_out <= '0;
    end else if (wr_rise) begin
      word_out <= '{valid: 1'b1, is_data: cmd_data_sel, byte_val: data_bus};
    end else if (scl_rise && bitcnt_reg == LPS_BITCNT_LAST) begin
      // msb first; the eighth edge completes the byte
      word_out <= '{valid: 1'b1, is_data: cmd_data_sel, byte_val: {shift_reg[6:0], ser_data}};
    end else begin
      word_out <= '0;
    end
  end

endmodule : lps_host_if

// *** rtl/lps_ctrl.sv ***
// module: display power, contrast and sleep control top
`timescale 1ns/1ps
module lps_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic par_sel,
  input wire logic cs_n,
  input wire logic cmd_data_sel,
  input wire logic wr_strobe,
  input wire logic [7:0] data_bus,
  input wire logic ser_data,
  input wire logic ser_clk,
  output lps_pkg::lps_settings_t settings,
  output logic booster_clk_en,
  output logic panel_force_high,
  output logic circuits_stopped,
  output logic asleep,
  output logic [7:0] data_byte,
  output logic data_strobe
);
  import lps_pkg::*;

  typedef enum logic [1:0] {LPS_RUN, LPS_SLEEP} lps_state_t;

  lps_word_t word;
  lps_state_t state_reg;
  lps_state_t state_next;
  logic is_cmd;
  logic [7:0] b;
  logic supplies_off;
  logic pc_hit;
  logic save_hit;
  logic contrast_hit;
  logic disp_hit;
  logic sys_hit;
  logic [LPS_N_SUPPLY-1:0] supply_reg;
  logic osc_reg;
  logic sleep_req_reg;
  logic [LPS_CONTRAST_W-1:0] contrast_reg;
  logic [LPS_BIT_CURSOR:LPS_BIT_DISP] disp_reg;
  logic cg_reg;

  // decoder shared by each command branch
  function automatic logic op_is(input logic [7:0] v, input logic [3:0] op);
    op_is = (v[7:4] == op);
  endfunction : op_is

  // reset pin reaches this block directly, never through the chip-select gate
  lps_host_if u_host (
    .clk(clk),
    .rst_n(rst_n),
    .par_sel(par_sel),
    .cs_n(cs_n),
    .cmd_data_sel(cmd_data_sel),
    .wr_strobe(wr_strobe),
    .data_bus(data_bus),
    .ser_data(ser_data),
    .ser_clk(ser_clk),
    .word_out(word)
  );

  assign is_cmd = word.valid && !word.is_data;
  assign b = word.byte_val;

  // ****************************************************************
  // command decode
  // ****************************************************************
  // decoded on the system clock, so writes land even while the display
  // oscillator is stopped and the host can wake the part
  assign pc_hit = is_cmd && op_is(b, LPS_OP_PWR_CTRL) && !b[LPS_BIT_PC_ZERO];
  assign save_hit = is_cmd && op_is(b, LPS_OP_PWR_SAVE);
  assign contrast_hit = is_cmd && op_is(b, LPS_OP_CONTRAST);
  assign disp_hit = is_cmd && op_is(b, LPS_OP_DISP_CTRL);
  assign sys_hit = is_cmd && op_is(b, LPS_OP_SYS_SET);

  // ****************************************************************
  // supply stage enables
  // ****************************************************************
  // one flop per stage, so any mix of internal and external supply works;
  // the stage index equals its bit in the power control command
  for (genvar g = 0; g < LPS_N_SUPPLY; g++) begin : g_supply
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        supply_reg[g] <= LPS_SUPPLY_RST[g];
      end else if (pc_hit) begin
        supply_reg[g] <= b[g];
      end
    end
  end

  // ****************************************************************
  // oscillator and sleep request
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_reg <= LPS_SETTINGS_RST.osc_en;
      sleep_req_reg <= LPS_SETTINGS_RST.sleep_req;
    end else if (save_hit) begin
      osc_reg <= b[LPS_BIT_OSC];
      sleep_req_reg <= b[LPS_BIT_SLEEP];
    end
  end

  // ****************************************************************
  // contrast level
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      contrast_reg <= LPS_CONTRAST_RST;
    end else if (contrast_hit) begin
      contrast_reg <= b[LPS_CONTRAST_W-1:0];
    end
  end

  // ****************************************************************
  // display and character generator settings
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_reg <= LPS_DISP_RST;
    end else if (disp_hit) begin
      disp_reg <= b[LPS_BIT_CURSOR:LPS_BIT_DISP];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cg_reg <= LPS_SETTINGS_RST.cg_use;
    end else if (sys_hit) begin
      cg_reg <= b[LPS_BIT_CG];
    end
  end

  // ****************************************************************
  // settings presented to the analogue side
  // ****************************************************************
  // plain wiring of the flops above, so the outputs stay registered
  assign settings = '{
    disp_on: disp_reg[LPS_BIT_DISP],
    cursor_on: disp_reg[LPS_BIT_CURSOR],
    blink_on: disp_reg[LPS_BIT_BLINK],
    dbl_cursor_on: disp_reg[LPS_BIT_DBL],
    osc_en: osc_reg,
    sleep_req: sleep_req_reg,
    regulator_en: supply_reg[LPS_BIT_REG],
    follower_en: supply_reg[LPS_BIT_FOL],
    booster_en: supply_reg[LPS_BIT_BOOST],
    cg_use: cg_reg,
    contrast: contrast_reg
  };

  // ****************************************************************
  // sleep sequencing
  // ****************************************************************
  // host must have already turned supplies and oscillator off
  assign supplies_off = !settings.regulator_en && !settings.follower_en
                        && !settings.booster_en && !settings.osc_en;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LPS_RUN: begin
        if (settings.sleep_req && supplies_off) begin
          state_next = LPS_SLEEP;
        end
      end
      LPS_SLEEP: begin
        if (!settings.sleep_req) begin
          state_next = LPS_RUN;
        end
      end
      default: begin
        state_next = LPS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LPS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep <= 1'b0;
      panel_force_high <= 1'b0;
      circuits_stopped <= 1'b0;
    end else begin
      asleep <= (state_next == LPS_SLEEP);
      panel_force_high <= (state_next == LPS_SLEEP);
      circuits_stopped <= (state_next == LPS_SLEEP);
    end
  end

  // booster pump clock exists only while the oscillator runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      booster_clk_en <= 1'b0;
    end else begin
      booster_clk_en <= settings.booster_en && settings.osc_en;
    end
  end

  // display data forwarded unchanged; memories live elsewhere and sleep
  // never touches this path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_byte <= 8'h00;
      data_strobe <= 1'b0;
    end else begin
      data_strobe <= word.valid && word.is_data;
      if (word.valid && word.is_data) begin
        data_byte <= b;
      end
    end
  end

endmodule : lps_ctrl

// *** dv/lps_ctrl_monitor.sv ***
// checker: port-level properties of the power and sleep control top
`timescale 1ns/1ps
module lps_ctrl_monitor (
  input logic clk,
  input logic rst_n,
  input logic par_sel,
  input logic cs_n,
  input logic cmd_data_sel,
  input logic wr_strobe,
  input logic [7:0] data_bus,
  input logic ser_data,
  input logic ser_clk,
  input lps_pkg::lps_settings_t settings,
  input logic booster_clk_en,
  input logic panel_force_high,
  input logic circuits_stopped,
  input logic asleep,
  input logic [7:0] data_byte,
  input logic data_strobe
);
  import lps_pkg::*;
  logic ws_reg;
  logic take;
  logic quiet;
  // parallel takes only; serial ones are judged by the bench
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ws_reg <= 1'b0;
    else ws_reg <= wr_strobe;
  end
  assign take = !cs_n && par_sel && wr_strobe && !ws_reg;
  assign quiet = settings.sleep_req && !settings.osc_en && !settings.regulator_en
    && !settings.follower_en && !settings.booster_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_desel_ignore: assert property (!$stable(settings) |-> $past(cs_n, 2) == 1'b0)
    else $error("settings moved while deselected");
  a_pwr_apply: assert property (take && !cmd_data_sel && data_bus[7:3] == 5'b01010
    |-> ##2 {settings.regulator_en, settings.follower_en, settings.booster_en}
    == $past(data_bus[2:0], 2)) else $error("power bits not applied");
  a_pwr_bit3: assert property (take && !cmd_data_sel && data_bus[7:3] == 5'b01011
    |-> ##2 $stable(settings)) else $error("bad power code accepted");
  a_contrast_set: assert property (take && !cmd_data_sel && data_bus[7:4] == 4'h7
    |-> ##2 settings.contrast == $past(data_bus[3:0], 2)) else $error("contrast not loaded");
  a_sleep_entry: assert property (quiet |=> asleep)
    else $error("sleep not entered");
  a_sleep_exit: assert property (!settings.sleep_req |=> !asleep)
    else $error("asleep without request");
  a_sleep_outs: assert property (panel_force_high == asleep && circuits_stopped == asleep)
    else $error("panel or circuits disagree with sleep");
  a_boost_osc: assert property (booster_clk_en == $past(settings.osc_en && settings.booster_en))
    else $error("booster clock without oscillator");
  a_data_write: assert property (take && cmd_data_sel
    |-> ##2 data_strobe && data_byte == $past(data_bus, 2) ##1 !data_strobe)
    else $error("data byte not passed");
endmodule : lps_ctrl_monitor
bind lps_ctrl lps_ctrl_monitor lps_ctrl_monitor_i (.clk, .rst_n, .par_sel, .cs_n, .cmd_data_sel,
  .wr_strobe, .data_bus, .ser_data, .ser_clk, .settings, .booster_clk_en, .panel_force_high,
  .circuits_stopped, .asleep, .data_byte, .data_strobe);

// *** dv/lps_host_model.sv ***
// host model: writes bytes over the parallel or serial path
`timescale 1ns/1ps
module lps_host_model (
  input wire logic clk,
  output logic par_sel,
  output logic cs_n,
  output logic cmd_data_sel,
  output logic wr_strobe,
  output logic [7:0] data_bus,
  output logic ser_data,
  output logic ser_clk
);
  initial {par_sel, cs_n, cmd_data_sel, wr_strobe, data_bus, ser_data, ser_clk} = 14'h3000;
  // nb below 8 leaves a partial serial frame for the deselect to discard
  task automatic xfer(input logic [7:0] b, input logic a0, ser, sel, input int nb);
    @(posedge clk);
    cs_n <= !sel;
    par_sel <= !ser;
    cmd_data_sel <= a0;
    data_bus <= b;
    if (!ser) begin
      @(posedge clk);
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
    end else for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      ser_data <= b[7-i];
      ser_clk <= 1'b0;
      @(posedge clk);
      ser_clk <= 1'b1;
    end
    repeat (3) @(posedge clk);
    // released lines show the inverse so stale values cannot pass
    cs_n <= 1'b1;
    ser_clk <= 1'b0;
    data_bus <= ~b;
    ser_data <= ~b[0];
  endtask : xfer
endmodule : lps_host_model

// *** dv/lps_ctrl_test.sv ***
// testbench: host traffic against a behavioural model of the held settings
`timescale 1ns/1ps
module lps_ctrl_test;
  import lps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic par_sel, cs_n, cmd_data_sel, wr_strobe, ser_data, ser_clk, e_slp;
  logic booster_clk_en, panel_force_high, circuits_stopped, asleep, data_strobe;
  logic [7:0] data_bus, data_byte, e_byte;
  lps_settings_t settings, e;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] q[$] = '{8'h42, 8'h57, 8'h7a, 8'h5c, 8'h50, 8'h40, 8'h41, 8'h73, 8'h3f, 8'h42, 8'h70};
  always #4 clk = ~clk;
  lps_ctrl lps_ctrl_i (.clk, .rst_n, .par_sel, .cs_n, .cmd_data_sel, .wr_strobe, .data_bus,
    .ser_data, .ser_clk, .settings, .booster_clk_en, .panel_force_high, .circuits_stopped,
    .asleep, .data_byte, .data_strobe);
  lps_host_model lps_host_model_i (.clk, .par_sel, .cs_n, .cmd_data_sel, .wr_strobe,
    .data_bus, .ser_data, .ser_clk);
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic put(input logic [7:0] b, input logic a0, ser, sel, input int nb);
    logic tk;
    tk = sel && (nb == 8 || !ser);
    lps_host_model_i.xfer(b, a0, ser, sel, nb);
    if (tk && a0) e_byte = b;
    if (tk && !a0) begin
      case (b[7:4])
        4'h3: {e.cursor_on, e.blink_on, e.dbl_cursor_on, e.disp_on} = b[3:0];
        4'h4: {e.osc_en, e.sleep_req} = b[1:0];
        4'h5: if (!b[3]) {e.regulator_en, e.follower_en, e.booster_en} = b[2:0];
        4'h6: e.cg_use = b[0];
        4'h7: e.contrast = b[3:0];
        default: ;
      endcase
    end
    if (e.sleep_req && !e.osc_en && !e.regulator_en && !e.follower_en && !e.booster_en) e_slp = 1;
    else if (!e.sleep_req) e_slp = 0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'(settings), 16'(e));
    chk(16'(booster_clk_en), 16'(e.booster_en & e.osc_en));
    chk(16'({asleep, panel_force_high, circuits_stopped}), 16'({3{e_slp}}));
    chk(16'(data_byte), 16'(e_byte));
  endtask : put
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // generous span: the whole run needs well under a fifth of it
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
  initial begin
    e = LPS_SETTINGS_RST;
    e_byte = 8'h00;
    e_slp = 1'b0;
    void'($urandom(32'hdbd942b2));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(settings), 16'(LPS_SETTINGS_RST));
    foreach (q[i]) put(q[i], 1'b0, 1'b0, 1'b1, 8);
    $display("power and sleep sequence done");
    put(8'h7f, 1'b0, 1'b0, 1'b0, 8);
    put(8'h7f, 1'b0, 1'b1, 1'b0, 8);
    put(8'h75, 1'b0, 1'b1, 1'b1, 5);
    put(8'h7c, 1'b0, 1'b1, 1'b1, 8);
    put(8'ha5, 1'b1, 1'b0, 1'b1, 8);
    put(8'h3c, 1'b1, 1'b1, 1'b1, 8);
    $display("select and framing done");
    repeat (40) put({4'(3 + $urandom % 5), 4'($urandom)}, $urandom % 4 == 0, $urandom % 2 == 0,
      $urandom % 8 != 0, ($urandom % 4 == 0) ? int'($urandom % 8) : 8);
    $display("random traffic done");
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(settings), 16'(LPS_SETTINGS_RST));
    chk(16'({asleep, booster_clk_en, data_strobe}), 16'h0000);
    rst_n <= 1'b1;
    e = LPS_SETTINGS_RST;
    e_byte = 8'h00;
    e_slp = 1'b0;
    put(8'h57, 1'b0, 1'b1, 1'b1, 8);
    $display("reset in mid-run done");
    test_done;
  end
endmodule : lps_ctrl_test
